/* File: aol_lamp_model.sv */
// far-side lamp bank: a lamp is lit while its line sits at the active level
`timescale 1ns/1ps
module aol_lamp_model (
	input wire logic [3:0] line_i,
	input wire logic active_high_i,
	output logic [3:0] lit_o
);
	assign lit_o = active_high_i ? line_i : ~line_i;
endmodule : aol_lamp_model

/* File: aol_line_state.sv */
// one alarm line: latch or track state with clear
`timescale 1ns/1ps
module aol_line_state (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic viol_i,
	input wire logic track_i,
	input wire logic clear_i,
	output logic state_o
);
	typedef struct packed {
		logic st;
	} aol_ls_s;
	aol_ls_s r;
	aol_ls_s next_r;

	always_comb
	begin
		next_r = r;
		if (track_i)
			next_r.st = viol_i; // [R5] [R6]
		else if (viol_i)
			next_r.st = 1'b1; // [R4]
		else if (clear_i)
			next_r.st = 1'b0; // [R7]
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			r <= '0;
		else
			r <= next_r;
	end

	assign state_o = r.st;
endmodule : aol_line_state

/* File: aol_or_map.sv */
// per-line OR of violations of the enabled channels assigned to that line
`timescale 1ns/1ps
module aol_or_map #(
	parameter int NCH = 8,
	parameter int NL = 4
) (
	input wire logic [NCH-1:0] viol_i,
	input wire logic [NCH-1:0] en_i,
	input wire logic [2*NCH-1:0] sel_i,
	output logic [NL-1:0] line_o
);
	always_comb
	begin
		line_o = '0;
		for (int c = 0; c < NCH; c++)
			if (en_i[c] && viol_i[c])
				line_o[sel_i[2*c +: 2]] = 1'b1; // [R2] [R3]
	end
endmodule : aol_or_map

/* File: aol_pkg.sv */
// package for the alarm output line block: register map, field layouts, types
package aol_pkg;
	localparam int NUM_LINES = 4;
	localparam int NUM_CHANS = 8;
	localparam int ADDR_W = 4;
	// register offsets (byte addresses, one word each)
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_CLEAR = 4'h4;
	localparam logic [3:0] OFF_ASSIGN = 4'h8;
	localparam logic [3:0] OFF_STATE = 4'hc;
	// control fields
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_POL_BIT = 1;
	localparam int CTRL_EN_LSB = 8;
	// clear and state register fields
	localparam int CLR_ALL_BIT = 4;
	localparam int STATE_IRQ_LSB = 4;
	localparam int STATE_MASK_LSB = 8;
	// values after reset
	localparam logic RST_MODE = 1'b0;
	localparam logic RST_POL = 1'b0;
	localparam logic [15:0] RST_ASSIGN = 16'h0000;
	localparam logic [3:0] RST_MASK = 4'h0;
	// idle level of all pins under the reset polarity (active low)
	localparam logic [3:0] RST_PINS = 4'hf;

	typedef enum logic {AOL_LATCH, AOL_TRACK} aol_mode_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} aol_bus_s;
endpackage : aol_pkg

/* File: aol_top.sv */
// top of the alarm output line block: registers, line states, polarity, interrupt
//
// Overview of operation
// [R1] four independent, separately clearable alarm lines
// [R2] any channel maps to one line, sharing allowed
// [R3] line is OR of its channels' violations
// [R4] latch: hold until clear, new scan, reset
// [R5] track: asserted only while reading out-of-limits
// [R6] track: deasserts itself when reading returns
// [R7] per-line clear affects that line only
// [R8] clear-all clears every line at once
// [R9] negative polarity: alarm drives low
// [R10] positive polarity: alarm drives high, common setting
// [R11] idle line drives the opposite level
`timescale 1ns/1ps
module aol_top #(
	parameter int NCH = aol_pkg::NUM_CHANS
) (
	input wire logic CLOCK_I,
	input wire logic SRST_I,
	input wire logic [NCH-1:0] VIOL_I,
	input wire logic SCAN_START_I,
	input wire logic [aol_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	output logic [aol_pkg::NUM_LINES-1:0] ALARM_O,
	output logic IRQ_O
);
	localparam int NL = aol_pkg::NUM_LINES;

	typedef struct packed {
		logic mode;
		logic pol;
		logic [NCH-1:0] en;
		logic [2*NCH-1:0] sel;
		logic [NL-1:0] irq_st;
		logic [NL-1:0] irq_mask;
		logic [NL-1:0] prev_line;
		logic [NL-1:0] pins;
		logic irq;
		logic [31:0] rdata;
	} aol_top_s;

	aol_top_s r;
	aol_top_s next_r;
	aol_pkg::aol_bus_s bus;
	logic [NL-1:0] raw;
	logic [NL-1:0] state;
	logic [NL-1:0] clr;

	assign bus.addr = ADDR_I;
	assign bus.wdata = WDATA_I;
	assign bus.wr = WR_I;
	assign bus.rd = RD_I;

	// clear strobes: per line, all lines, or a new scan
	always_comb
	begin
		clr = '0;
		if (SCAN_START_I)
			clr = '1; // [R4]
		if (bus.wr && bus.addr == aol_pkg::OFF_CLEAR)
		begin
			clr = clr | bus.wdata[NL-1:0]; // [R7]
			if (bus.wdata[aol_pkg::CLR_ALL_BIT])
				clr = '1; // [R8]
		end
	end

	aol_or_map #(
		.NCH(NCH),
		.NL(NL)
	) u_map (
		.viol_i(VIOL_I),
		.en_i(r.en),
		.sel_i(r.sel),
		.line_o(raw)
	);

	for (genvar g = 0; g < NL; g++)
	begin : g_line
		aol_line_state u_ls (
			.clk_i(CLOCK_I),
			.srst_i(SRST_I),
			.viol_i(raw[g]),
			.track_i(r.mode),
			.clear_i(clr[g]),
			.state_o(state[g])
		); // [R1]
	end

	always_comb
	begin
		next_r = r;
		next_r.rdata = '0;
		next_r.prev_line = state;
		// rising line state is an event; set wins over software clear
		if (bus.wr && bus.addr == aol_pkg::OFF_STATE)
			next_r.irq_st = r.irq_st & ~bus.wdata[aol_pkg::STATE_IRQ_LSB +: NL];
		next_r.irq_st = next_r.irq_st | (state & ~r.prev_line);
		if (bus.wr)
		begin
			if (bus.addr == aol_pkg::OFF_CTRL)
			begin
				next_r.mode = bus.wdata[aol_pkg::CTRL_MODE_BIT];
				next_r.pol = bus.wdata[aol_pkg::CTRL_POL_BIT];
				next_r.en = bus.wdata[aol_pkg::CTRL_EN_LSB +: NCH];
			end
			else if (bus.addr == aol_pkg::OFF_ASSIGN)
				next_r.sel = bus.wdata[2*NCH-1:0]; // [R2]
			else if (bus.addr == aol_pkg::OFF_STATE)
				next_r.irq_mask = bus.wdata[aol_pkg::STATE_MASK_LSB +: NL];
		end
		if (bus.rd)
		begin
			if (bus.addr == aol_pkg::OFF_CTRL)
			begin
				next_r.rdata[aol_pkg::CTRL_MODE_BIT] = r.mode;
				next_r.rdata[aol_pkg::CTRL_POL_BIT] = r.pol;
				next_r.rdata[aol_pkg::CTRL_EN_LSB +: NCH] = r.en;
			end
			else if (bus.addr == aol_pkg::OFF_ASSIGN)
				next_r.rdata[2*NCH-1:0] = r.sel;
			else if (bus.addr == aol_pkg::OFF_STATE)
			begin
				next_r.rdata[NL-1:0] = state;
				next_r.rdata[aol_pkg::STATE_IRQ_LSB +: NL] = r.irq_st;
				next_r.rdata[aol_pkg::STATE_MASK_LSB +: NL] = r.irq_mask;
			end
		end
		// pol 1 = active high, 0 = active low, one setting for all
		next_r.pins = r.pol ? state : ~state; // [R9] [R10] [R11]
		next_r.irq = |(next_r.irq_st & next_r.irq_mask);
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
		begin
			r <= '0;
			r.mode <= aol_pkg::RST_MODE;
			r.pol <= aol_pkg::RST_POL;
			r.sel <= aol_pkg::RST_ASSIGN;
			r.irq_mask <= aol_pkg::RST_MASK;
			r.pins <= aol_pkg::RST_PINS; // [R11]
		end
		else
			r <= next_r;
	end

	assign RDATA_O = r.rdata;
	assign ALARM_O = r.pins;
	assign IRQ_O = r.irq;
endmodule : aol_top

/* File: aol_top_properties.sv */
// checker for the alarm line block ports
`timescale 1ns/1ps
module aol_top_properties #(
	parameter int NCH = 8
) (
	input wire logic CLOCK_I,
	input wire logic SRST_I,
	input wire logic [NCH-1:0] VIOL_I,
	input wire logic SCAN_START_I,
	input wire logic [aol_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [31:0] RDATA_O,
	input wire logic [aol_pkg::NUM_LINES-1:0] ALARM_O,
	input wire logic IRQ_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SRST_I);
	sequence flush(go);
		go && VIOL_I == '0 ##1 VIOL_I == '0 && !WR_I;
	endsequence
	sequence calm;
		!SCAN_START_I && !WR_I && $stable(VIOL_I);
	endsequence
	sequence go_track_high;
		WR_I && ADDR_I == aol_pkg::OFF_CTRL && WDATA_I[1:0] == 2'b11
		##1 VIOL_I == '0 && !WR_I;
	endsequence
	a_reset_idle: assert property ($past(SRST_I) |-> ALARM_O == 4'hf && !IRQ_O)
		else $error("alarm not idle after reset");
	a_scan_clears: assert property (flush(SCAN_START_I) |=> ALARM_O inside {4'h0, 4'hf})
		else $error("scan start left a line active");
	a_clear_all: assert property (flush(WR_I && ADDR_I == aol_pkg::OFF_CLEAR
		&& WDATA_I[aol_pkg::CLR_ALL_BIT])
		|=> ALARM_O inside {4'h0, 4'hf}) else $error("clear all left a line active");
	a_quiet_stable: assert property (calm [*4] |=> $stable(ALARM_O))
		else $error("alarm moved with no cause");
	a_single_clear: assert property (calm ##1 WR_I && ADDR_I == aol_pkg::OFF_CLEAR
		&& WDATA_I == 32'h1 && !SCAN_START_I && $stable(VIOL_I) ##1 calm [*2]
		|=> $stable(ALARM_O[3:1])) else $error("line clear touched other lines");
	a_track_release: assert property (go_track_high |=> ##1 ALARM_O == 4'h0)
		else $error("track line stayed active with no violation");
endmodule : aol_top_properties
bind aol_top aol_top_properties #(.NCH(NCH)) i_aol_top_properties (.CLOCK_I(CLOCK_I),
	.SRST_I(SRST_I), .VIOL_I(VIOL_I), .SCAN_START_I(SCAN_START_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .ALARM_O(ALARM_O),
	.IRQ_O(IRQ_O));

/* File: aol_top_tb_top.sv */
// self-checking bench for the alarm line block
`timescale 1ns/1ps
module aol_top_tb_top;
	logic clk = 0, rst = 1, scan = 0, wr = 0, rd = 0, rdp = 0, pol = 0, irq;
	logic [7:0] viol = '0, v;
	logic [3:0] addr = '0, alarm, lit, lv;
	logic [31:0] wd = '0, rdata, expq[$];
	logic [15:0] map;
	int failures = 0, compares = 0;
	always #12.5 clk = ~clk;
	aol_top i_aol_top (.CLOCK_I(clk), .SRST_I(rst), .VIOL_I(viol), .SCAN_START_I(scan),
		.ADDR_I(addr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.ALARM_O(alarm), .IRQ_O(irq));
	aol_lamp_model i_aol_lamp_model (.line_i(alarm), .active_high_i(pol), .lit_o(lit));
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			failures++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic wrt(logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrt
	task automatic step(logic [7:0] nv, logic [31:0] n);
		@(posedge clk);
		viol <= nv;
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : step
	task automatic rdx(logic [3:0] a, logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		expq.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rdx
	task automatic give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	always @(posedge clk)
		rdp <= rd;
	always @(negedge clk)
		if (rdp)
			chk("rdata", rdata, expq.pop_front());
	initial
	begin
		void'($urandom(73));
		// channel 0 is always violating and mapped to line 0
		map = 16'($urandom) & 16'hfffc;
		v = 8'($urandom) | 8'h01;
		lv = '0;
		for (int c = 0; c < 8; c++)
			if (v[c])
				lv[map[2*c+:2]] = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wrt(4'h0, 32'hff00);
		wrt(4'h8, {16'h0, map});
		wrt(4'hc, 32'h0ff0);
		rdx(4'h0, 32'hff00);
		rdx(4'h8, {16'h0, map});
		step(v, 3);
		step(8'h0, 3);
		chk("lamp", lit, lv);
		chk("irq", irq, 1'b1);
		rdx(4'hc, {20'h0, 4'hf, lv, lv});
		wrt(4'hc, 32'h0ff0);
		step(8'h0, 1);
		chk("irq", irq, 1'b0);
		wrt(4'h4, 32'h1);
		step(8'h0, 3);
		chk("lamp", lit, lv & 4'he);
		wrt(4'h4, 32'h10);
		step(8'h0, 3);
		chk("lamp", lit, 4'h0);
		step(v, 3);
		chk("lamp", lit, lv);
		@(posedge clk);
		viol <= '0;
		scan <= 1'b1;
		@(posedge clk);
		scan <= 1'b0;
		step(8'h0, 3);
		chk("lamp", lit, 4'h0);
		@(posedge clk);
		pol <= 1'b1;
		wrt(4'h0, 32'hff03);
		step(8'h0, 3);
		chk("alarm", alarm, 4'h0);
		chk("lamp", lit, 4'h0);
		step(v, 3);
		chk("alarm", alarm, lv);
		chk("lamp", lit, lv);
		step(8'h0, 3);
		chk("alarm", alarm, 4'h0);
		give_verdict();
	end
	initial
	begin
		#20us;
		failures++;
		give_verdict();
	end
endmodule : aol_top_tb_top
